//--- pkg/psc_map.svh
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// Clock
`define PSC_CLK_PERIOD_NS      8

// Management register indexes
`define PSC_REG_CONTROL        5'h00
`define PSC_REG_ID_HIGH        5'h02
`define PSC_REG_ID_LOW         5'h03
`define PSC_REG_USER           5'h14
`define PSC_REG_STATUS_EXT     5'h1c
`define PSC_REG_CONFIG_A       5'h1d
`define PSC_REG_CONFIG_B       5'h1e

// Field positions
`define PSC_CTL_LOOPBACK_BIT   14
`define PSC_CTL_ISOLATE_BIT    10
`define PSC_STS_POLARITY_BIT   6
`define PSC_CFA_WIDEN_BIT      7
`define PSC_CFA_FLASH_BIT      11
`define PSC_CFB_NOLP_BIT       0
`define PSC_CFB_SERIAL_BIT     1
`define PSC_CFB_LONG_BIT       4
`define PSC_CFB_HEART_BIT      5

// Reset values
`define PSC_USER_RESET         16'h0000
`define PSC_JAM_BYTE           8'h55

// Timer acceleration
`define PSC_ACCEL_X1           9'h001
`define PSC_ACCEL_X16          9'h010
`define PSC_ACCEL_X64          9'h040
`define PSC_ACCEL_X256         9'h100
`define PSC_ACCEL_NO_AN        2'h3
`define PSC_TIMER_BASE_NS      10000
`define PSC_VIOLATION_LIMIT    5'h1f

// LED timing
`define PSC_LED_WIDEN_NS       42000000
`define PSC_LED_FLASH_NS       42000000
`define PSC_LED_SLOW_NS        500000000

`endif

//--- pkg/psc_pkg.sv
package psc_pkg;

   typedef enum logic [1:0]
   {
      PSC_LED_PLAIN,
      PSC_LED_WIDEN,
      PSC_LED_FLASH,
      PSC_LED_FLASH_SLOW
   } psc_led_mode_t;

   typedef logic [8:0] psc_accel_step_t;

endpackage

//--- rtl/psc_led_shaper.sv
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_led_shaper
#(
   parameter int WIDEN_CYCLES = 1,
   parameter int FLASH_CYCLES = 1,
   parameter int SLOW_CYCLES  = 1
)
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // Control
   input  wire logic clear,
   input  wire logic widen_en,
   input  wire logic flash_en,
   input  wire logic activity,
   // Indicator
   output logic      led
);

   localparam int CW = $clog2(SLOW_CYCLES + 1) + 1;

   psc_pkg::psc_led_mode_t mode;
   logic [CW-1:0]          period;
   logic [CW-1:0]          hold;
   logic [CW-1:0]          phase_cnt;
   logic                   phase;
   logic                   busy;

   always_comb
   begin
      mode = psc_pkg::PSC_LED_PLAIN;
      if (flash_en && widen_en)
         mode = psc_pkg::PSC_LED_FLASH_SLOW;
      else if (flash_en)
         mode = psc_pkg::PSC_LED_FLASH;
      else if (widen_en)
         mode = psc_pkg::PSC_LED_WIDEN;
   end

   always_comb
   begin
      unique case (mode)
         psc_pkg::PSC_LED_PLAIN:      period = CW'(1);
         psc_pkg::PSC_LED_WIDEN:      period = CW'(WIDEN_CYCLES);
         psc_pkg::PSC_LED_FLASH:      period = CW'(FLASH_CYCLES);
         psc_pkg::PSC_LED_FLASH_SLOW: period = CW'(SLOW_CYCLES);
      endcase
   end

   assign busy = activity || (hold != '0);

   // Hold reloads on every activity cycle so a pulse lasts a full period
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         hold <= '0;
      else if (clear || mode == psc_pkg::PSC_LED_PLAIN)
         hold <= '0;
      else if (activity)
         hold <= period - CW'(1);
      else if (hold != '0)
         hold <= hold - CW'(1);
   end

   // Blink phase starts high at the first busy cycle
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_cnt <= '0;
         phase     <= 1'b1;
      end
      else if (clear || !busy)
      begin
         phase_cnt <= '0;
         phase     <= 1'b1;
      end
      else if (phase_cnt >= period - CW'(1))
      begin
         phase_cnt <= '0;
         phase     <= !phase;
      end
      else
         phase_cnt <= phase_cnt + CW'(1);
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         led <= 1'b0;
      else if (clear)
         led <= 1'b0;
      else
      begin
         unique case (mode)
            psc_pkg::PSC_LED_PLAIN:      led <= activity;
            psc_pkg::PSC_LED_WIDEN:      led <= busy;
            psc_pkg::PSC_LED_FLASH:      led <= busy && phase;
            psc_pkg::PSC_LED_FLASH_SLOW: led <= busy && phase;
         endcase
      end
   end

endmodule

//--- rtl/psc_quad_port_ctrl.sv
`timescale 1ns/1ps
`include "psc_map.svh"


module psc_quad_port_ctrl
#(
   parameter int PORTS        = 4,
   parameter int WIDEN_CYCLES = (`PSC_LED_WIDEN_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS,
   parameter int FLASH_CYCLES = (`PSC_LED_FLASH_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS,
   parameter int SLOW_CYCLES  = (`PSC_LED_SLOW_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS
)
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   // Timer test controls
   input  wire logic                 timer_accel_test,
   input  wire logic [1:0]           timer_accel_factor,
   // Shared straps
   input  wire logic                 strict_link_check,
   input  wire logic                 led_widen_on,
   input  wire logic                 led_flash_on,
   // Per-port straps
   input  wire logic [PORTS-1:0]     jam_on_transmit,
   input  wire logic [PORTS-1:0]     isolate_strap,
   input  wire logic [PORTS-1:0]     polarity_fix_n,
   input  wire logic [PORTS-1:0]     long_line_sense,
   input  wire logic [PORTS-1:0]     heartbeat_strap,
   input  wire logic [PORTS-1:0]     loopback_strap,
   input  wire logic [PORTS-1:0]     link_pulse_suppress,
   input  wire logic [PORTS-1:0]     serial_mode_strap,
   input  wire logic [PORTS-1:0]     power_off_strap,
   // Identity
   input  wire logic [24:3]          org_identifier,
   input  wire logic [5:0]           model_number,
   input  wire logic [3:0]           revision_number,
   // Port status from the transceiver core
   input  wire logic [PORTS-1:0]     speed_100,
   input  wire logic [PORTS-1:0]     link_detect,
   input  wire logic [PORTS-1:0]     code_violation,
   input  wire logic [PORTS-1:0]     polarity_reversal,
   input  wire logic [PORTS-1:0]     an_finished,
   input  wire logic [PORTS-1:0]     an_restart,
   input  wire logic [PORTS-1:0]     activity,
   // Transmit from the MAC side
   input  wire logic [PORTS-1:0]     transmit_request,
   input  wire logic [8*PORTS-1:0]   tx_byte,
   // Receive from the line side
   input  wire logic [PORTS-1:0]     line_rx_valid,
   input  wire logic [8*PORTS-1:0]   line_rx_byte,
   // Transmit to the line side
   output logic      [PORTS-1:0]     line_tx_en,
   output logic      [8*PORTS-1:0]   line_tx_byte,
   // Receive to the MAC side
   output logic      [PORTS-1:0]     rx_valid,
   output logic      [8*PORTS-1:0]   rx_byte,
   // Decoded management transactions
   input  wire logic                 mgmt_write,
   input  wire logic                 mgmt_read,
   input  wire logic [1:0]           mgmt_port,
   input  wire logic [4:0]           mgmt_addr,
   input  wire logic [15:0]          mgmt_wdata,
   output logic      [15:0]          mgmt_rdata,
   output logic                      mgmt_rvalid,
   // Timer controls
   output logic      [PORTS-1:0]     timer_tick,
   output logic                      an_permitted,
   // Port controls and status
   output logic      [PORTS-1:0]     link_ok,
   output logic      [PORTS-1:0]     polarity_correct,
   output logic      [PORTS-1:0]     long_line_active,
   output logic      [PORTS-1:0]     heartbeat_en,
   output logic      [PORTS-1:0]     loopback_active,
   output logic      [PORTS-1:0]     link_pulse_en,
   output logic      [PORTS-1:0]     isolated,
   output logic      [PORTS-1:0]     port_power_down,
   output logic      [PORTS-1:0]     serial_indication,
   output logic      [PORTS-1:0]     negotiation_complete,
   output logic      [16*PORTS-1:0]  user_reg_mirror,
   output logic      [PORTS-1:0]     led_out
);

   localparam int BASE_CYCLES = (`PSC_TIMER_BASE_NS + `PSC_CLK_PERIOD_NS - 1)
                                / `PSC_CLK_PERIOD_NS;
   localparam int AW          = $clog2(BASE_CYCLES + 256 + 1);

   psc_pkg::psc_accel_step_t accel_step;
   logic [15:0]              rd_word [PORTS];

   // Step per cycle; the prescaler wraps after BASE_CYCLES units
   always_comb
   begin
      accel_step = `PSC_ACCEL_X1;
      if (timer_accel_test)
      begin
         unique case (timer_accel_factor)
            2'h0: accel_step = `PSC_ACCEL_X1;
            2'h1: accel_step = `PSC_ACCEL_X16;
            2'h2: accel_step = `PSC_ACCEL_X64;
            2'h3: accel_step = `PSC_ACCEL_X256;
         endcase
      end
   end

   // Negotiation timing breaks down at the top factor
   assign an_permitted = !(timer_accel_test && timer_accel_factor == `PSC_ACCEL_NO_AN);

   genvar gi;
   generate
      for (gi = 0; gi < PORTS; gi++)
      begin : g_port
         logic          wr_hit;
         logic          pwr_off;
         logic          strap_taken;
         logic          ctl_isolate;
         logic          ctl_loopback;
         logic          cfa_widen;
         logic          cfa_flash;
         logic          cfb_nolp;
         logic          cfb_serial;
         logic          cfb_long;
         logic          cfb_heart;
         logic [15:0]   user_reg;
         logic          pol_flag;
         logic [4:0]    viol_cnt;
         logic          an_done;
         logic [AW-1:0] accel_acc;
         logic [AW-1:0] next_accel_acc;
         logic          loop_on;
         logic [7:0]    tx_in;

         assign wr_hit  = mgmt_write && mgmt_port == 2'(gi);
         assign pwr_off = power_off_strap[gi];
         assign tx_in   = tx_byte[8*gi +: 8];

         // Timer prescaler per port
         assign next_accel_acc = accel_acc + AW'(accel_step);

         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
            begin
               accel_acc      <= '0;
               timer_tick[gi] <= 1'b0;
            end
            else if (pwr_off)
            begin
               accel_acc      <= '0;
               timer_tick[gi] <= 1'b0;
            end
            else if (next_accel_acc >= AW'(BASE_CYCLES))
            begin
               accel_acc      <= next_accel_acc - AW'(BASE_CYCLES);
               timer_tick[gi] <= 1'b1;
            end
            else
            begin
               accel_acc      <= next_accel_acc;
               timer_tick[gi] <= 1'b0;
            end
         end

         // Strap is sampled on the first edge after reset or powerdown
         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
            begin
               strap_taken <= 1'b0;
               ctl_isolate <= 1'b0;
            end
            else if (pwr_off)
            begin
               strap_taken <= 1'b0;
               ctl_isolate <= 1'b0;
            end
            else if (!strap_taken)
            begin
               strap_taken <= 1'b1;
               ctl_isolate <= isolate_strap[gi];
            end
            else if (wr_hit && mgmt_addr == `PSC_REG_CONTROL)
               ctl_isolate <= mgmt_wdata[`PSC_CTL_ISOLATE_BIT];
         end

         // Writable management bits
         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
            begin
               ctl_loopback <= 1'b0;
               cfa_widen    <= 1'b0;
               cfa_flash    <= 1'b0;
               cfb_nolp     <= 1'b0;
               cfb_serial   <= 1'b0;
               cfb_long     <= 1'b0;
               cfb_heart    <= 1'b0;
               user_reg     <= `PSC_USER_RESET;
            end
            else if (pwr_off)
            begin
               ctl_loopback <= 1'b0;
               cfa_widen    <= 1'b0;
               cfa_flash    <= 1'b0;
               cfb_nolp     <= 1'b0;
               cfb_serial   <= 1'b0;
               cfb_long     <= 1'b0;
               cfb_heart    <= 1'b0;
               user_reg     <= `PSC_USER_RESET;
            end
            else if (wr_hit)
            begin
               unique case (mgmt_addr)
                  `PSC_REG_CONTROL:
                     ctl_loopback <= mgmt_wdata[`PSC_CTL_LOOPBACK_BIT];
                  `PSC_REG_CONFIG_A:
                  begin
                     cfa_widen <= mgmt_wdata[`PSC_CFA_WIDEN_BIT];
                     cfa_flash <= mgmt_wdata[`PSC_CFA_FLASH_BIT];
                  end
                  `PSC_REG_CONFIG_B:
                  begin
                     cfb_nolp   <= mgmt_wdata[`PSC_CFB_NOLP_BIT];
                     cfb_serial <= mgmt_wdata[`PSC_CFB_SERIAL_BIT];
                     cfb_long   <= mgmt_wdata[`PSC_CFB_LONG_BIT];
                     cfb_heart  <= mgmt_wdata[`PSC_CFB_HEART_BIT];
                  end
                  `PSC_REG_USER:
                     user_reg <= mgmt_wdata;
                  default:
                     ;
               endcase
            end
         end

         // Violation count restarts whenever the link itself drops
         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
               viol_cnt <= '0;
            else if (pwr_off || !link_detect[gi])
               viol_cnt <= '0;
            else if (code_violation[gi] && viol_cnt != `PSC_VIOLATION_LIMIT)
               viol_cnt <= viol_cnt + 5'h01;
         end

         // Flag follows detection only while correction is active at 10M
         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
               pol_flag <= 1'b0;
            else if (pwr_off)
               pol_flag <= 1'b0;
            else
               pol_flag <= polarity_correct[gi];
         end

         // Done wins over a restart seen in the same cycle
         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
               an_done <= 1'b0;
            else if (pwr_off)
               an_done <= 1'b0;
            else if (an_finished[gi])
               an_done <= 1'b1;
            else if (an_restart[gi])
               an_done <= 1'b0;
         end

         assign loop_on = loopback_strap[gi] || ctl_loopback;

         // Datapath; loopback feeds transmit back into receive
         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
            begin
               line_tx_en[gi]            <= 1'b0;
               line_tx_byte[8*gi +: 8]   <= 8'h00;
               rx_valid[gi]              <= 1'b0;
               rx_byte[8*gi +: 8]        <= 8'h00;
            end
            else
            begin
               line_tx_en[gi] <= transmit_request[gi] && !ctl_isolate && !loop_on
                                 && !pwr_off;
               line_tx_byte[8*gi +: 8] <= jam_on_transmit[gi] && transmit_request[gi]
                                          ? `PSC_JAM_BYTE : tx_in;
               if (ctl_isolate || pwr_off)
               begin
                  rx_valid[gi]       <= 1'b0;
                  rx_byte[8*gi +: 8] <= 8'h00;
               end
               else if (loop_on)
               begin
                  rx_valid[gi]       <= transmit_request[gi];
                  rx_byte[8*gi +: 8] <= jam_on_transmit[gi] && transmit_request[gi]
                                        ? `PSC_JAM_BYTE : tx_in;
               end
               else
               begin
                  rx_valid[gi]       <= line_rx_valid[gi];
                  rx_byte[8*gi +: 8] <= line_rx_byte[8*gi +: 8];
               end
            end
         end

         assign link_ok[gi]          = link_detect[gi] && !(strict_link_check
                                       && viol_cnt == `PSC_VIOLATION_LIMIT);
         assign polarity_correct[gi] = polarity_reversal[gi] && !polarity_fix_n[gi]
                                       && !speed_100[gi];
         assign long_line_active[gi] = long_line_sense[gi] || cfb_long;
         assign heartbeat_en[gi]     = heartbeat_strap[gi] || cfb_heart;
         assign loopback_active[gi]  = loop_on;
         assign link_pulse_en[gi]    = speed_100[gi]
                                       || !(link_pulse_suppress[gi] || cfb_nolp);
         assign isolated[gi]         = ctl_isolate;
         assign port_power_down[gi]  = pwr_off;
         assign serial_indication[gi] = (serial_mode_strap[gi] || cfb_serial)
                                        && !speed_100[gi];
         assign negotiation_complete[gi]   = an_done;
         assign user_reg_mirror[16*gi +: 16] = user_reg;

         // Read view of this port's registers
         always_comb
         begin
            rd_word[gi] = 16'h0000;
            unique case (mgmt_addr)
               `PSC_REG_CONTROL:
               begin
                  rd_word[gi][`PSC_CTL_LOOPBACK_BIT] = ctl_loopback;
                  rd_word[gi][`PSC_CTL_ISOLATE_BIT]  = ctl_isolate;
               end
               `PSC_REG_ID_HIGH:
                  rd_word[gi] = org_identifier[18:3];
               `PSC_REG_ID_LOW:
                  rd_word[gi] = {org_identifier[24:19], model_number, revision_number};
               `PSC_REG_USER:
                  rd_word[gi] = user_reg;
               `PSC_REG_STATUS_EXT:
                  rd_word[gi][`PSC_STS_POLARITY_BIT] = pol_flag;
               `PSC_REG_CONFIG_A:
               begin
                  rd_word[gi][`PSC_CFA_WIDEN_BIT] = cfa_widen;
                  rd_word[gi][`PSC_CFA_FLASH_BIT] = cfa_flash;
               end
               `PSC_REG_CONFIG_B:
               begin
                  rd_word[gi][`PSC_CFB_NOLP_BIT]   = cfb_nolp;
                  rd_word[gi][`PSC_CFB_SERIAL_BIT] = cfb_serial;
                  rd_word[gi][`PSC_CFB_LONG_BIT]   = cfb_long;
                  rd_word[gi][`PSC_CFB_HEART_BIT]  = cfb_heart;
               end
               default:
                  rd_word[gi] = 16'h0000;
            endcase
         end

         // One shaper per port keeps LED timing independent
         psc_led_shaper
         #(
            .WIDEN_CYCLES (WIDEN_CYCLES),
            .FLASH_CYCLES (FLASH_CYCLES),
            .SLOW_CYCLES  (SLOW_CYCLES)
         )
         u_led
         (
            .clk_sys  (clk_sys),
            .reset_n  (reset_n),
            .clear    (pwr_off),
            .widen_en (led_widen_on || cfa_widen),
            .flash_en (led_flash_on || cfa_flash),
            .activity (activity[gi]),
            .led      (led_out[gi])
         );
      end
   endgenerate

   // Read data is registered one cycle after the read strobe
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mgmt_rdata  <= 16'h0000;
         mgmt_rvalid <= 1'b0;
      end
      else
      begin
         mgmt_rvalid <= mgmt_read;
         if (mgmt_read)
            mgmt_rdata <= rd_word[mgmt_port];
      end
   end

endmodule

//--- verification/psc_props.sv
`timescale 1ns/1ps

module psc_props
#(
   parameter int PORTS = 4
)
(
   // Clock and reset
   input wire logic               clk_sys,
   input wire logic               reset_n,
   // Straps and core events
   input wire logic               timer_accel_test,
   input wire logic [1:0]         timer_accel_factor,
   input wire logic [PORTS-1:0]   an_finished,
   input wire logic [PORTS-1:0]   an_restart,
   input wire logic [PORTS-1:0]   power_off_strap,
   input wire logic [PORTS-1:0]   transmit_request,
   input wire logic [PORTS-1:0]   jam_on_transmit,
   input wire logic [PORTS-1:0]   loopback_strap,
   input wire logic [PORTS-1:0]   long_line_sense,
   input wire logic [PORTS-1:0]   heartbeat_strap,
   input wire logic [PORTS-1:0]   link_pulse_suppress,
   input wire logic [PORTS-1:0]   speed_100,
   // Outputs watched
   input wire logic [PORTS-1:0]   isolated,
   input wire logic [PORTS-1:0]   loopback_active,
   input wire logic [PORTS-1:0]   long_line_active,
   input wire logic [PORTS-1:0]   heartbeat_en,
   input wire logic [PORTS-1:0]   link_pulse_en,
   input wire logic [PORTS-1:0]   serial_indication,
   input wire logic [PORTS-1:0]   negotiation_complete,
   input wire logic               an_permitted,
   input wire logic [PORTS-1:0]   rx_valid,
   input wire logic [PORTS-1:0]   line_tx_en,
   input wire logic [8*PORTS-1:0] line_tx_byte,
   input wire logic [16*PORTS-1:0] user_reg_mirror
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_jam_byte: assert property (transmit_request[2] && jam_on_transmit[2]
      && !isolated[2] && !loopback_active[2] && !power_off_strap[2]
      |=> line_tx_byte[23:16] == 8'h55) else $error("jam");
   chk_iso_quiet: assert property (isolated[3] && $past(isolated[3])
      |-> !rx_valid[3] && !line_tx_en[3]) else $error("isolated port active");
   chk_loop_quiet: assert property (loopback_active[1] |=> !line_tx_en[1])
      else $error("loopback sends");
   chk_strap_or: assert property (((long_line_sense & ~long_line_active) |
      (heartbeat_strap & ~heartbeat_en) | (loopback_strap & ~loopback_active)) == '0)
      else $error("or");
   chk_nolp_slow: assert property ((link_pulse_suppress & ~speed_100
      & link_pulse_en) == '0) else $error("link pulses on");
   chk_serial_fast: assert property ((serial_indication & speed_100) == '0)
      else $error("serial at 100M");
   chk_an_block: assert property (an_permitted
      == !(timer_accel_test && timer_accel_factor == 2'h3)) else $error("an permit");
   chk_done_rise: assert property (an_finished[0] && !power_off_strap[0]
      |=> negotiation_complete[0]) else $error("done not set");
   chk_done_fall: assert property (an_restart[0] && !an_finished[0]
      && !power_off_strap[0] |=> !negotiation_complete[0]) else $error("done not cleared");
   chk_pdown_user: assert property (power_off_strap[0]
      |=> user_reg_mirror[15:0] == 16'h0000) else $error("user reg kept");
endmodule

bind psc_quad_port_ctrl psc_props #(.PORTS(PORTS)) props_u (.*);

//--- verification/psc_line_src.sv
`timescale 1ns/1ps

module psc_line_src
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Line side toward the block
   output logic      [3:0]  line_rx_valid,
   output logic      [31:0] line_rx_byte,
   output logic      [3:0]  activity
);
   // Pattern moves every cycle, so a stale byte never matches
   always_ff @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
         line_rx_byte <= 32'h0;
      else
         line_rx_byte <= line_rx_byte * 32'h5 + 32'h01010101;
   assign line_rx_valid = line_rx_byte[7:4];
   assign activity      = line_rx_byte[11:8];
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps

module tb;
   logic        clk_sys, reset_n, timer_accel_test, strict_link_check, led_widen_on;
   logic        led_flash_on, mgmt_write, mgmt_read, mgmt_rvalid, an_permitted;
   logic [1:0]  timer_accel_factor, mgmt_port;
   logic [3:0]  jam_on_transmit, isolate_strap, polarity_fix_n, long_line_sense;
   logic [3:0]  heartbeat_strap, loopback_strap, link_pulse_suppress, serial_mode_strap;
   logic [3:0]  power_off_strap, speed_100, link_detect, code_violation, polarity_reversal;
   logic [3:0]  an_finished, an_restart, activity, transmit_request, line_rx_valid;
   logic [3:0]  line_tx_en, rx_valid, timer_tick, link_ok, polarity_correct, isolated;
   logic [3:0]  long_line_active, heartbeat_en, loopback_active, link_pulse_en, led_out;
   logic [3:0]  port_power_down, serial_indication, negotiation_complete, revision_number;
   logic [5:0]  model_number;
   logic [4:0]  mgmt_addr;
   logic [24:3] org_identifier;
   logic [15:0] mgmt_wdata, mgmt_rdata;
   logic [31:0] tx_byte, line_rx_byte, line_tx_byte, rx_byte;
   logic [63:0] user_reg_mirror, mir;
   logic [15:0] exp_q[$];
   int          error_cnt = 0;
   int          n_checks = 0;
   int          i;
   integer      seed;

   psc_line_src far_u (.*);
   psc_quad_port_ctrl #(.WIDEN_CYCLES(8), .FLASH_CYCLES(8), .SLOW_CYCLES(20)) dut_u (.*);

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic end_of_test();
      if (error_cnt == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask

   // One management access; for a read, d is the expected word
   task automatic mg(input logic w, input logic [1:0] p, input logic [4:0] a,
      input logic [15:0] d);
      @(posedge clk_sys);
      mgmt_write <= w;
      mgmt_read  <= !w;
      mgmt_port  <= p;
      mgmt_addr  <= a;
      mgmt_wdata <= d;
      if (!w)
         exp_q.push_back(d);
      @(posedge clk_sys);
      mgmt_write <= 1'b0;
      mgmt_read  <= 1'b0;
      @(negedge clk_sys);
   endtask

   always @(negedge clk_sys)
      if (mgmt_rvalid === 1'b1)
         cmp(mgmt_rdata, exp_q.pop_front());

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      end_of_test();
   end

   initial
   begin
      {reset_n, timer_accel_test, strict_link_check, led_widen_on, led_flash_on, mgmt_write,
       mgmt_read, timer_accel_factor, mgmt_port, jam_on_transmit, polarity_fix_n, long_line_sense,
       heartbeat_strap, loopback_strap, link_pulse_suppress, power_off_strap, speed_100,
       link_detect, code_violation, polarity_reversal, an_finished, an_restart,
       transmit_request, mgmt_addr, mgmt_wdata, tx_byte} = '0;
      isolate_strap = 4'h8;
      serial_mode_strap = 4'h8;
      seed = 32'h0a8ff302;
      {org_identifier, model_number, revision_number} = $random(seed);
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(negedge clk_sys);
      cmp(isolated, 4'h8);
      mg(0, 2'd0, 5'h14, 16'h0000);
      mg(0, 2'd1, 5'h02, org_identifier[18:3]);
      mg(0, 2'd1, 5'h03, {org_identifier[24:19], model_number, revision_number});
      mg(0, 2'd2, 5'h07, 16'h0000);
      mir = {$random(seed), $random(seed)};
      for (i = 0; i < 4; i++)
         mg(1, i[1:0], 5'h14, mir[16*i+:16]);
      for (i = 0; i < 4; i++)
         mg(0, i[1:0], 5'h14, mir[16*i+:16]);
      cmp(user_reg_mirror, mir);
      mg(1, 2'd0, 5'h00, 16'h0400);
      cmp(isolated, 4'h9);
      transmit_request <= 4'hf;
      jam_on_transmit <= 4'hf;
      tx_byte <= $random(seed);
      repeat (2) @(negedge clk_sys);
      cmp({line_tx_en, rx_valid & isolated, rx_byte[7:0]}, 16'h6000);
      mg(1, 2'd1, 5'h00, 16'h4000);
      @(negedge clk_sys);
      cmp({loopback_active[1], line_tx_en[1], rx_valid[1], rx_byte[15:8]}, 11'h555);
      polarity_reversal <= 4'h6;
      polarity_fix_n <= 4'h4;
      mg(0, 2'd1, 5'h1c, 16'h0040);
      mg(0, 2'd2, 5'h1c, 16'h0000);
      cmp(polarity_correct[2:1], 2'b01);
      mg(1, 2'd2, 5'h1e, 16'h0031);
      cmp({long_line_active[2], heartbeat_en[2], link_pulse_en[2],
           serial_indication}, 7'h68);
      speed_100 <= 4'hc;
      @(negedge clk_sys);
      cmp({link_pulse_en[2], serial_indication}, 5'h10);
      link_detect <= 4'hf;
      strict_link_check <= 1'b1;
      // Violations spaced out so each one counts on its own
      for (i = 0; i < 31; i++)
      begin
         @(posedge clk_sys);
         if (i == 30)
            cmp(link_ok[0], 1'b1);
         code_violation <= 4'h1;
         @(posedge clk_sys);
         code_violation <= 4'h0;
      end
      repeat (2) @(negedge clk_sys);
      cmp(link_ok[1:0], 2'b10);
      an_finished <= 4'h1;
      @(posedge clk_sys);
      an_finished <= 4'h0;
      an_restart <= 4'h1;
      timer_accel_test <= 1'b1;
      timer_accel_factor <= 2'h3;
      @(negedge clk_sys);
      cmp(an_permitted, 1'b0);
      i = 0;
      repeat (10)
      begin
         @(negedge clk_sys);
         i += timer_tick[1];
      end
      cmp(i >> 1, 1);
      @(posedge clk_sys);
      an_restart <= 4'h0;
      timer_accel_factor <= 2'h1;
      @(negedge clk_sys);
      cmp(an_permitted, 1'b1);
      timer_accel_test <= 1'b0;
      power_off_strap <= 4'h1;
      @(posedge clk_sys);
      power_off_strap <= 4'h0;
      mg(0, 2'd0, 5'h14, 16'h0000);
      mg(0, 2'd1, 5'h14, mir[31:16]);
      {loopback_strap, long_line_sense, heartbeat_strap, link_pulse_suppress}
         <= 16'($random(seed));
      led_widen_on <= 1'b1;
      while (!activity[1])
         @(negedge clk_sys);
      repeat (8) @(negedge clk_sys);
      cmp(led_out[1], 1'b1);
      led_flash_on <= 1'b1;
      end_of_test();
   end
endmodule
